// *** tb_timer16_control_status.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_timer16_control_status;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic irq_mask_in = 1'b1;
  logic ext_run = 1'b0;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  logic rd_d = 1'b0;
  logic cap_a, cap_b, ext_clk, irq_out, pa, pa_oe_n, pb, pb_oe_n;
  logic [7:0] rdata_out, got, dl, v;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  logic [7:0] want[4] = '{8'd12, 8'd25, 8'd6, 8'd8};
  int error_cnt = 0;
  int n_checks = 0;
  int i;
  timer_pins_model u_pins (.clk_in(clk_in), .ext_run_in(ext_run), .lvl_a_in(lvl_a), .lvl_b_in(lvl_b),
    .cap_a_out(cap_a), .cap_b_out(cap_b), .ext_clk_out(ext_clk));
  timer16_control_status u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .irq_mask_in(irq_mask_in),
    .capture_pin_a_in(cap_a), .capture_pin_b_in(cap_b), .ext_timer_clock_pin_in(ext_clk),
    .rdata_out(rdata_out), .irq_out(irq_out), .compare_pin_a_out(pa), .compare_pin_a_oe_n_out(pa_oe_n),
    .compare_pin_b_out(pb), .compare_pin_b_oe_n_out(pb_oe_n));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // mask 00 means the value is only kept in got
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    exp_q.push_back({m, x});
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask : rd
  always @(posedge clk_in) begin
    rd_d <= rd_in;
    if (rd_d) begin
      got = rdata_out;
      e = exp_q.pop_front();
      if (e[15:8] != 8'h00) check(rdata_out & e[15:8], e[7:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    conclude();
  end
  initial begin
    v = 8'($urandom(7));
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(4'h2, 8'hff, 8'h00);
    rd(4'h1, 8'hff, 8'h00);
    rd(4'h6, 8'hff, 8'h80);
    rd(4'h3, 8'h07, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(4'h2, v);
      rd(4'h2, 8'hff, v);
    end
    wr(4'h1, 8'hc0);
    wr(4'h2, 8'h1d);
    repeat (4) @(posedge clk_in);
    check({pa, pb, pa_oe_n, pb_oe_n}, 8'h0c);
    wr(4'h2, 8'h18);
    wr(4'h1, 8'h00);
    repeat (4) @(posedge clk_in);
    check({pa, pb, pa_oe_n, pb_oe_n}, 8'h03);
    for (i = 0; i < 4; i++) begin
      wr(4'h3, 8'h04); // freeze set, other bits kept zero
      wr(4'h9, 8'h00);
      wr(4'h1, {4'h0, i[1:0], 2'h1});
      ext_run <= (i == 3);
      wr(4'h3, 8'h00);
      repeat (48) @(posedge clk_in);
      wr(4'h3, 8'h04);
      rd(4'h8, 8'h00, 8'h00);
      rd(4'h9, 8'h00, 8'h00);
      dl = got - 8'hfc;
      check(8'(dl + 8'd2 - want[i] <= 8'd4), 8'h01);
    end
    ext_run <= 1'b0;
    repeat (20) @(posedge clk_in);
    rd(4'h9, 8'hff, got);
    wr(4'h6, 8'hff);
    wr(4'h7, 8'hfe);
    wr(4'he, 8'hff);
    wr(4'hf, 8'hff);
    rd(4'h3, 8'h00, 8'h00);
    wr(4'h9, 8'h00);
    wr(4'h2, 8'h25);
    wr(4'h1, 8'hc4);
    irq_mask_in <= 1'b0;
    wr(4'h3, 8'h00);
    for (i = 0; i < 200 && irq_out !== 1'b1; i++) @(posedge clk_in);
    check({pa, pb, irq_out}, 8'h07);
    wr(4'h3, 8'h04);
    rd(4'h3, 8'hff, 8'h6c);
    rd(4'hb, 8'h00, 8'h00);
    rd(4'h3, 8'hff, 8'h6c);
    rd(4'h9, 8'h00, 8'h00);
    rd(4'h7, 8'h00, 8'h00);
    rd(4'hf, 8'h00, 8'h00);
    rd(4'h3, 8'hff, 8'h04);
    check(8'(irq_out), 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h02);
    wr(4'h1, 8'h04);
    lvl_a <= 1'b1;
    lvl_b <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(4'h3, 8'hff, 8'h80);
    lvl_a <= 1'b0;
    lvl_b <= 1'b0;
    repeat (8) @(posedge clk_in);
    rd(4'h3, 8'hff, 8'h90);
    rd(4'h5, 8'h00, 8'h00);
    rd(4'hd, 8'h00, 8'h00);
    rd(4'h3, 8'hff, 8'h00);
    conclude();
  end
endmodule : tb_timer16_control_status
`default_nettype wire

// *** timer16_control_status.sv ***
`timescale 1ns/1ns
`default_nettype none
module timer16_control_status #(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic irq_mask_in,
  input wire logic capture_pin_a_in,
  input wire logic capture_pin_b_in,
  input wire logic ext_timer_clock_pin_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  output logic compare_pin_a_out,
  output logic compare_pin_a_oe_n_out,
  output logic compare_pin_b_out,
  output logic compare_pin_b_oe_n_out
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  timer16_pkg::state_s s_q, s_d;
  timer16_pkg::bus_req_s req;
  timer16_pkg::pins_in_s pins;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign pins = '{cap_a: capture_pin_a_in, cap_b: capture_pin_b_in, ext_clk: ext_timer_clock_pin_in};

  always_comb begin
    logic pwm;
    logic single;
    logic tick;
    logic edge_a;
    logic edge_b;
    logic edge_e;
    logic hit_a;
    logic hit_b;
    logic [2:0] div_mask;
    logic [4:0] set;
    logic [4:0] clr;
    logic acc_cap_a;
    logic acc_cmp_a;
    logic acc_cnt;
    logic acc_cap_b;
    logic acc_cmp_b;
    logic [7:0] rd_val;
    s_d = s_q;
    pwm = s_q.ctrl_two[timer16_pkg::C2_PWM];
    single = s_q.ctrl_two[timer16_pkg::C2_SINGLE] && !pwm;
    set = 5'h00;
    clr = 5'h00;
    rd_val = 8'h00;
    hit_a = 1'b0;
    hit_b = 1'b0;
    // two-flop synchronisers, edges from stages 1 and 2
    s_d.sync_a = {s_q.sync_a[1:0], pins.cap_a};
    s_d.sync_b = {s_q.sync_b[1:0], pins.cap_b};
    s_d.sync_e = {s_q.sync_e[1:0], pins.ext_clk};
    edge_a = s_q.ctrl_one[timer16_pkg::C1_EDGE_A] ? (s_q.sync_a[1] && !s_q.sync_a[2])
                                                   : (!s_q.sync_a[1] && s_q.sync_a[2]);
    edge_b = s_q.ctrl_two[timer16_pkg::C2_EDGE_B] ? (s_q.sync_b[1] && !s_q.sync_b[2])
                                                   : (!s_q.sync_b[1] && s_q.sync_b[2]);
    edge_e = s_q.ctrl_two[timer16_pkg::C2_EXT_EDGE] ? (s_q.sync_e[1] && !s_q.sync_e[2])
                                                     : (!s_q.sync_e[1] && s_q.sync_e[2]);
    // prescaler and tick selection
    unique case (s_q.ctrl_two[timer16_pkg::C2_CLK_HI:timer16_pkg::C2_CLK_LO])
      timer16_pkg::CLK_DIV4: div_mask = 3'h3;
      timer16_pkg::CLK_DIV2: div_mask = 3'h1;
      timer16_pkg::CLK_DIV8: div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
    tick = 1'b0;
    if (!s_q.freeze) begin
      s_d.presc = s_q.presc + 3'h1;
      if (s_q.ctrl_two[timer16_pkg::C2_CLK_HI:timer16_pkg::C2_CLK_LO] == timer16_pkg::CLK_EXT) begin
        tick = HAS_EXT_CLK && edge_e;
      end else begin
        tick = (s_q.presc & div_mask) == div_mask;
      end
    end
    // counting and compare events
    if (tick) begin
      s_d.cnt = s_q.cnt + 16'h0001;
      hit_a = s_q.cnt == s_q.cmp_a_act;
      hit_b = s_q.cnt == s_q.cmp_b_act;
      if (s_q.cnt == timer16_pkg::CNT_TOP) begin
        set[2] = 1'b1;
      end
      if (pwm) begin
        if (hit_b) begin
          s_d.cnt = timer16_pkg::CNT_RELOAD;
          set[4] = 1'b1;
          s_d.pin_a = s_q.ctrl_one[timer16_pkg::C1_LVL_B];
          s_d.cmp_a_act = s_q.cmp_a;
          s_d.cmp_b_act = s_q.cmp_b;
        end else if (hit_a) begin
          s_d.pin_a = s_q.ctrl_one[timer16_pkg::C1_LVL_A];
        end
      end else if (single) begin
        if (s_q.pulse_run && hit_a) begin
          s_d.pin_a = s_q.ctrl_one[timer16_pkg::C1_LVL_A];
          s_d.pulse_run = 1'b0;
        end
        set[0] = hit_b;
      end else begin
        set[3] = hit_a;
        set[0] = hit_b;
        if (hit_a) begin
          s_d.pin_a = s_q.ctrl_one[timer16_pkg::C1_LVL_A];
        end
        if (hit_b) begin
          s_d.pin_b = s_q.ctrl_one[timer16_pkg::C1_LVL_B];
        end
      end
    end
    if (!pwm) begin
      s_d.cmp_a_act = s_q.cmp_a;
      s_d.cmp_b_act = s_q.cmp_b;
    end
    // captures
    if (edge_a && !pwm) begin
      if (single) begin
        s_d.cnt = timer16_pkg::CNT_RELOAD;
        s_d.pin_a = s_q.ctrl_one[timer16_pkg::C1_LVL_B];
        s_d.pulse_run = 1'b1;
      end
      s_d.cap_a = s_q.cnt;
      set[4] = 1'b1;
    end
    if (edge_b) begin
      s_d.cap_b = s_q.cnt;
      set[1] = 1'b1;
    end
    // forced levels
    if (s_q.ctrl_one[timer16_pkg::C1_FORCE_A]) begin
      s_d.pin_a = s_q.ctrl_one[timer16_pkg::C1_LVL_A];
    end
    if (s_q.ctrl_one[timer16_pkg::C1_FORCE_B]) begin
      s_d.pin_b = s_q.ctrl_one[timer16_pkg::C1_LVL_B];
    end
    // register reads
    acc_cap_a = (req.rd || req.wr) && req.addr == timer16_pkg::ADDR_CAP_A_LO;
    acc_cmp_a = (req.rd || req.wr) && req.addr == timer16_pkg::ADDR_CMP_A_LO;
    acc_cnt = (req.rd || req.wr) && req.addr == timer16_pkg::ADDR_CNT_LO;
    acc_cap_b = (req.rd || req.wr) && req.addr == timer16_pkg::ADDR_CAP_B_LO;
    acc_cmp_b = (req.rd || req.wr) && req.addr == timer16_pkg::ADDR_CMP_B_LO;
    if (req.rd) begin
      unique case (req.addr)
        timer16_pkg::ADDR_CTRL_ONE: rd_val = s_q.ctrl_one;
        timer16_pkg::ADDR_CTRL_TWO: rd_val = s_q.ctrl_two;
        timer16_pkg::ADDR_FLAGS: rd_val = {s_q.flags, s_q.freeze, 2'b00};
        timer16_pkg::ADDR_CAP_A_HI: rd_val = s_q.cap_a[15:8];
        timer16_pkg::ADDR_CAP_A_LO: rd_val = s_q.cap_a[7:0];
        timer16_pkg::ADDR_CMP_A_HI: rd_val = s_q.cmp_a[15:8];
        timer16_pkg::ADDR_CMP_A_LO: rd_val = s_q.cmp_a[7:0];
        timer16_pkg::ADDR_CNT_HI: rd_val = s_q.cnt[15:8];
        timer16_pkg::ADDR_CNT_LO: rd_val = s_q.cnt_lo_hold;
        timer16_pkg::ADDR_ALT_HI: rd_val = s_q.cnt[15:8];
        timer16_pkg::ADDR_ALT_LO: rd_val = s_q.alt_lo_hold;
        timer16_pkg::ADDR_CAP_B_HI: rd_val = s_q.cap_b[15:8];
        timer16_pkg::ADDR_CAP_B_LO: rd_val = s_q.cap_b[7:0];
        timer16_pkg::ADDR_CMP_B_HI: rd_val = s_q.cmp_b[15:8];
        timer16_pkg::ADDR_CMP_B_LO: rd_val = s_q.cmp_b[7:0];
        default: rd_val = 8'h00;
      endcase
      if (req.addr == timer16_pkg::ADDR_CNT_HI) begin
        s_d.cnt_lo_hold = s_q.cnt[7:0];
      end
      if (req.addr == timer16_pkg::ADDR_ALT_HI) begin
        s_d.alt_lo_hold = s_q.cnt[7:0];
      end
      if (req.addr == timer16_pkg::ADDR_FLAGS) begin
        s_d.armed = s_q.flags; // first step of clearing
      end
    end
    if (req.rd && req.addr != timer16_pkg::ADDR_CNT_LO && req.addr != timer16_pkg::ADDR_CNT_HI) begin
      s_d.cnt_lo_hold = s_q.cnt[7:0];
    end
    if (req.rd && req.addr != timer16_pkg::ADDR_ALT_LO && req.addr != timer16_pkg::ADDR_ALT_HI) begin
      s_d.alt_lo_hold = s_q.cnt[7:0];
    end
    // two-step clears: flags read, then low-byte access
    clr[4] = acc_cap_a && s_q.armed[4];
    clr[3] = acc_cmp_a && s_q.armed[3];
    clr[2] = acc_cnt && s_q.armed[2];
    clr[1] = acc_cap_b && s_q.armed[1];
    clr[0] = acc_cmp_b && s_q.armed[0];
    s_d.armed = s_d.armed & ~clr;
    s_d.flags = (s_q.flags & ~clr) | set;
    // register writes
    if (req.wr) begin
      unique case (req.addr)
        timer16_pkg::ADDR_CTRL_ONE: s_d.ctrl_one = req.wdata;
        timer16_pkg::ADDR_CTRL_TWO: s_d.ctrl_two = req.wdata;
        timer16_pkg::ADDR_FLAGS: s_d.freeze = req.wdata[timer16_pkg::F_FREEZE];
        timer16_pkg::ADDR_CMP_A_HI: s_d.cmp_a[15:8] = req.wdata;
        timer16_pkg::ADDR_CMP_A_LO: s_d.cmp_a[7:0] = req.wdata;
        timer16_pkg::ADDR_CMP_B_HI: s_d.cmp_b[15:8] = req.wdata;
        timer16_pkg::ADDR_CMP_B_LO: s_d.cmp_b[7:0] = req.wdata;
        timer16_pkg::ADDR_CNT_LO, timer16_pkg::ADDR_ALT_LO: s_d.cnt = timer16_pkg::CNT_RESET;
        default: s_d.cnt = s_d.cnt;
      endcase
    end
    s_d.rdata = rd_val;
    // pin enables: compare logic runs regardless, freeze blanks pins
    s_d.pin_a_oe = s_q.ctrl_two[timer16_pkg::C2_PIN_A_EN] && !s_q.freeze;
    s_d.pin_b_oe = s_q.ctrl_two[timer16_pkg::C2_PIN_B_EN] && !s_q.freeze && !pwm && !single;
    // shared interrupt line
    s_d.irq = !irq_mask_in && (
      (s_q.ctrl_one[timer16_pkg::C1_CAP_IE] && (s_q.flags[4] || s_q.flags[1])) ||
      (s_q.ctrl_one[timer16_pkg::C1_CMP_IE] && (s_q.flags[3] || s_q.flags[0])) ||
      (s_q.ctrl_one[timer16_pkg::C1_OVF_IE] && s_q.flags[2]));
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl_one <= timer16_pkg::CTRL_RESET;
      s_q.ctrl_two <= timer16_pkg::CTRL_RESET;
      s_q.cnt <= timer16_pkg::CNT_RESET;
      s_q.cnt_lo_hold <= timer16_pkg::CNT_RESET[7:0];
      s_q.alt_lo_hold <= timer16_pkg::CNT_RESET[7:0];
      s_q.cmp_a <= timer16_pkg::CMP_RESET;
      s_q.cmp_b <= timer16_pkg::CMP_RESET;
      s_q.cmp_a_act <= timer16_pkg::CMP_RESET;
      s_q.cmp_b_act <= timer16_pkg::CMP_RESET;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;
  assign compare_pin_a_out = s_q.pin_a;
  assign compare_pin_a_oe_n_out = !s_q.pin_a_oe;
  assign compare_pin_b_out = s_q.pin_b;
  assign compare_pin_b_oe_n_out = !s_q.pin_b_oe;
endmodule : timer16_control_status
`default_nettype wire

// *** timer16_control_status_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module timer16_checker #(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic irq_mask_in,
  input wire logic capture_pin_a_in,
  input wire logic capture_pin_b_in,
  input wire logic ext_timer_clock_pin_in,
  input wire logic [7:0] rdata_out,
  input wire logic irq_out,
  input wire logic compare_pin_a_out,
  input wire logic compare_pin_a_oe_n_out,
  input wire logic compare_pin_b_out,
  input wire logic compare_pin_b_oe_n_out
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic frz_q;
  logic [1:0] quiet_q;
  logic still;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // shadow of the control bits, plus cycles since the last control write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      frz_q <= 1'b0;
      quiet_q <= 2'h0;
    end else if (clk_en_in && wr_in && addr_in inside {4'h1, 4'h2, 4'h3}) begin
      quiet_q <= 2'h0;
      if (addr_in == 4'h1) c2_q <= wdata_in;
      if (addr_in == 4'h2) c1_q <= wdata_in;
      if (addr_in == 4'h3) frz_q <= wdata_in[2];
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  assign still = quiet_q == 2'h3 && !frz_q && c2_q[5:4] == 2'h0;
  sequence s_rd(logic [3:0] a);
    rd_in && clk_en_in && addr_in == a;
  endsequence
  sequence s_masked;
    irq_mask_in [*3];
  endsequence
  AST_MASK: assert property (s_masked |-> !irq_out)
    else $error("irq while masked");
  AST_NO_EN: assert property (quiet_q == 2'h3 && c1_q[7:5] == 3'h0 |-> !irq_out)
    else $error("irq with enables clear");
  AST_RD_ONE: assert property (s_rd(4'h2) |=> rdata_out == $past(c1_q))
    else $error("control one readback");
  AST_RD_TWO: assert property (s_rd(4'h1) |=> rdata_out == $past(c2_q))
    else $error("control two readback");
  AST_FORCE_A: assert property (still && c1_q[3] && c2_q[7] |-> compare_pin_a_out == c1_q[0])
    else $error("forced level a");
  AST_FORCE_B: assert property (still && c1_q[4] && c2_q[6] |-> compare_pin_b_out == c1_q[2])
    else $error("forced level b");
  AST_OE_A: assert property (quiet_q == 2'h3 && !frz_q |-> compare_pin_a_oe_n_out == !c2_q[7])
    else $error("pin a enable");
  AST_OE_B: assert property (still |-> compare_pin_b_oe_n_out == !c2_q[6])
    else $error("pin b enable");
endmodule : timer16_checker
bind timer16_control_status timer16_checker #(.HAS_EXT_CLK(HAS_EXT_CLK)) u_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .irq_mask_in(irq_mask_in),
  .capture_pin_a_in(capture_pin_a_in), .capture_pin_b_in(capture_pin_b_in),
  .ext_timer_clock_pin_in(ext_timer_clock_pin_in), .rdata_out(rdata_out), .irq_out(irq_out),
  .compare_pin_a_out(compare_pin_a_out), .compare_pin_a_oe_n_out(compare_pin_a_oe_n_out),
  .compare_pin_b_out(compare_pin_b_out), .compare_pin_b_oe_n_out(compare_pin_b_oe_n_out)
);
`default_nettype wire

// *** timer16_pkg.sv ***
package timer16_pkg;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h2;
  localparam logic [3:0] ADDR_FLAGS = 4'h3;
  localparam logic [3:0] ADDR_CAP_A_HI = 4'h4;
  localparam logic [3:0] ADDR_CAP_A_LO = 4'h5;
  localparam logic [3:0] ADDR_CMP_A_HI = 4'h6;
  localparam logic [3:0] ADDR_CMP_A_LO = 4'h7;
  localparam logic [3:0] ADDR_CNT_HI = 4'h8;
  localparam logic [3:0] ADDR_CNT_LO = 4'h9;
  localparam logic [3:0] ADDR_ALT_HI = 4'ha;
  localparam logic [3:0] ADDR_ALT_LO = 4'hb;
  localparam logic [3:0] ADDR_CAP_B_HI = 4'hc;
  localparam logic [3:0] ADDR_CAP_B_LO = 4'hd;
  localparam logic [3:0] ADDR_CMP_B_HI = 4'he;
  localparam logic [3:0] ADDR_CMP_B_LO = 4'hf;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  // control one bit positions
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_FORCE_B = 4;
  localparam int C1_FORCE_A = 3;
  localparam int C1_LVL_B = 2;
  localparam int C1_EDGE_A = 1;
  localparam int C1_LVL_A = 0;
  // control two bit positions
  localparam int C2_PIN_A_EN = 7;
  localparam int C2_PIN_B_EN = 6;
  localparam int C2_SINGLE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE_B = 1;
  localparam int C2_EXT_EDGE = 0;
  // flags register bit positions
  localparam int F_CAP_A = 7;
  localparam int F_CMP_A = 6;
  localparam int F_OVF = 5;
  localparam int F_CAP_B = 4;
  localparam int F_CMP_B = 3;
  localparam int F_FREEZE = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic cap_a;
    logic cap_b;
    logic ext_clk;
  } pins_in_s;

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [4:0] flags;
    logic freeze;
    logic [4:0] armed;
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cmp_a_act;
    logic [15:0] cmp_b_act;
    logic [15:0] cap_a;
    logic [15:0] cap_b;
    logic [7:0] cap_lo_hold;
    logic [7:0] cnt_lo_hold;
    logic [7:0] alt_lo_hold;
    logic [2:0] presc;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_e;
    logic pulse_run;
    logic pin_a;
    logic pin_b;
    logic pin_a_oe;
    logic pin_b_oe;
    logic irq;
    logic [7:0] rdata;
  } state_s;
endpackage : timer16_pkg

// *** timer_pins_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module timer_pins_model (
  input wire logic clk_in,
  input wire logic ext_run_in,
  input wire logic lvl_a_in,
  input wire logic lvl_b_in,
  output var logic cap_a_out,
  output var logic cap_b_out,
  output var logic ext_clk_out
);
  logic [1:0] div_q = 2'h0;
  initial begin
    cap_a_out = 1'b0;
    cap_b_out = 1'b0;
    ext_clk_out = 1'b0;
  end
  // pins move just after an edge; ext clock stands still when not running
  always @(posedge clk_in) begin
    cap_a_out <= lvl_a_in;
    cap_b_out <= lvl_b_in;
    if (ext_run_in) begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) begin
        ext_clk_out <= !ext_clk_out;
      end
    end
  end
endmodule : timer_pins_model
`default_nettype wire
